// [tmr_channel.sv]
`timescale 1ns/10ps
// One channel: holds the refreshed reading and the frozen copy for paired reads
module tmr_channel (
   // Clock and reset
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_rst_n,
   input  wire logic                            i_ce,
   // Control
   input  wire logic                            i_enable,
   input  wire logic                            i_update,
   input  wire logic [tmr_pkg::TMR_READ_W-1:0]  i_sample,
   input  wire logic                            i_freeze,
   // Result
   output logic      [tmr_pkg::TMR_READ_W-1:0]  o_live,
   output logic      [tmr_pkg::TMR_READ_W-1:0]  o_frozen
);
   import tmr_pkg::*;

   typedef struct packed {
      logic [TMR_READ_W-1:0] live;
      logic [TMR_READ_W-1:0] frozen;
   } tmr_ch_state_t;

   tmr_ch_state_t s_q;
   tmr_ch_state_t s_d;

   // Next state: refresh while enabled, fixed code otherwise
   always_comb begin
      s_d = s_q;
      if (!i_enable) begin
         s_d.live = TMR_CODE_DISABLED;
      end else if (i_update) begin
         s_d.live = i_sample;
      end
      if (i_freeze) begin
         s_d.frozen = s_d.live;
      end
   end

   // State register
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '{live: TMR_CODE_DISABLED, frozen: TMR_CODE_DISABLED};
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_live   = s_q.live;
   assign o_frozen = s_q.frozen;
endmodule : tmr_channel

// [tmr_host_model.sv]
`timescale 1ns/10ps
// *******************
// Register host model
// *******************
module tmr_host_model (
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_reg_rdata,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic      [7:0] o_reg_addr,
   output logic      [7:0] o_reg_wdata
);
   // Idle request lines at start
   initial {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = 18'h0;
   // Write (address and data) or read; released address and data lines show the inverse
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] dw,
                       output logic [7:0] dr);
      @(posedge i_sys_clk);
      #1;
      {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = {w, ~w, a, dw};
      @(posedge i_sys_clk);
      #1;
      {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = {2'b00, ~a, ~dw};
      dr = i_reg_rdata;
      // A read ending at 0x85 or 0x86 is followed by a read elsewhere
      if (!w && (a == 8'h85 || a == 8'h86)) xfer(1'b0, 8'h70, 8'h00, dw);
   endtask : xfer
endmodule : tmr_host_model

// [tmr_pkg.sv]
package tmr_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] TMR_OFS_OUTPUT_OVERRIDE   = 8'h70;
   localparam logic [7:0] TMR_OFS_CH1_UPPER         = 8'h80;
   localparam logic [7:0] TMR_OFS_CH1_LOWER         = 8'h81;
   localparam logic [7:0] TMR_OFS_CH2_UPPER         = 8'h82;
   localparam logic [7:0] TMR_OFS_CH2_LOWER         = 8'h83;
   localparam logic [7:0] TMR_OFS_INT_UPPER         = 8'h84;
   localparam logic [7:0] TMR_OFS_INT_LOWER         = 8'h85;
   localparam logic [7:0] TMR_OFS_ALARM_FIRST       = 8'h86;
   localparam logic [7:0] TMR_OFS_ALARM_SECOND      = 8'h87;
   // ************************************************************
   // Fields, codes and reset values
   // ************************************************************
   localparam int         TMR_NUM_CH                = 3;
   localparam int         TMR_READ_W                = 11;
   localparam int         TMR_OVR_W                 = 6;
   localparam int         TMR_OVR_GP2_BIT           = 0;
   localparam int         TMR_OVR_GP3_BIT           = 1;
   localparam int         TMR_OVR_HV1_BIT           = 2;
   localparam logic [5:0] TMR_OVR_RESET             = 6'h00;
   localparam logic [10:0] TMR_CODE_DISABLED        = 11'h700;
   localparam logic [10:0] TMR_CODE_MAX             = 11'h3ff;
   localparam logic [7:0] TMR_RD_UNMAPPED           = 8'h00;
   // Conversion slot length per channel, in ns
   localparam int         TMR_SLOT_NS               = 1000;
   localparam int         TMR_CLK_NS                = 10;
   localparam int         TMR_SLOT_CYC              = (TMR_SLOT_NS + TMR_CLK_NS - 1) / TMR_CLK_NS;
endpackage : tmr_pkg

// [tmr_readout.sv]
`timescale 1ns/10ps
// Overview of operation
// - Read/write override register: bit0 gp2, bit1 gp3, bits2-5 hv1-4, bits6-7 zero.
// - Each of three channels reads as an upper and a lower byte register.
// - Enabled channels refresh their reading automatically on each new conversion.
// - Refresh interval grows with the number of enabled channels sharing conversions.
// - Reading an upper byte freezes the reading as updated in that same cycle for the following lower byte.
// - Upper byte holds bits 10..3; lower holds bits 2..0 at 7..5, rest zero.
// - Readings are 11-bit two's complement, bit 10 is the sign.
// - One code step is a quarter degree Celsius.
// - A disabled or reset channel reads the minus 64 degree code 0x700.
// - Readings above 255.75 degrees clamp to 0x3ff; negatives are not clamped.
// - First alarm register: ch1 bit0, ch2 bit1, internal bit2, rest zero.
// - Second alarm register: ch1 bit0, ch2 bit1, internal bit2, rest zero.
// - Override bits act only on outputs configured for host control.
module tmr_readout #(
   parameter int SLOT_CYC = tmr_pkg::TMR_SLOT_CYC
) (
   // Clock, reset, enable
   input  wire logic                                   i_sys_clk,
   input  wire logic                                   i_rst_n,
   input  wire logic                                   i_ce,
   // Register port from the serial engine
   input  wire logic                                   i_reg_wr,
   input  wire logic                                   i_reg_rd,
   input  wire logic [7:0]                             i_reg_addr,
   input  wire logic [7:0]                             i_reg_wdata,
   output logic      [7:0]                             o_reg_rdata,
   // Measurement front end
   input  wire logic [tmr_pkg::TMR_NUM_CH-1:0]         i_ch_enable,
   input  wire logic [tmr_pkg::TMR_NUM_CH-1:0]         i_ch_sample_valid,
   input  wire logic [tmr_pkg::TMR_NUM_CH*12-1:0]      i_ch_sample,
   output logic      [tmr_pkg::TMR_NUM_CH-1:0]         o_ch_convert,
   // Comparator alarms
   input  wire logic [tmr_pkg::TMR_NUM_CH-1:0]         i_alarm_first,
   input  wire logic [tmr_pkg::TMR_NUM_CH-1:0]         i_alarm_second,
   // Output control
   input  wire logic [tmr_pkg::TMR_OVR_W-1:0]          i_out_host_ctl,
   input  wire logic [tmr_pkg::TMR_OVR_W-1:0]          i_out_default,
   output logic                                        o_general_output_two,
   output logic                                        o_general_output_three,
   output logic      [3:0]                             o_hv_output
);
   import tmr_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [1:0] {
      TMR_SEQ_CH1 = 2'b00,
      TMR_SEQ_CH2 = 2'b01,
      TMR_SEQ_INT = 2'b10
   } tmr_seq_t;

   typedef struct packed {
      logic [TMR_OVR_W-1:0] ovr;
      tmr_seq_t             seq;
      logic [15:0]          slot_cnt;
      logic [TMR_NUM_CH-1:0] convert;
      logic [7:0]           rdata;
      logic [TMR_OVR_W-1:0] outs;
   } tmr_state_t;

   tmr_state_t s_q;
   tmr_state_t s_d;

   logic [TMR_NUM_CH-1:0]            upd;
   logic [TMR_NUM_CH-1:0]            frz;
   logic [TMR_NUM_CH*TMR_READ_W-1:0] samp;
   logic [TMR_NUM_CH*TMR_READ_W-1:0] live;
   logic [TMR_NUM_CH*TMR_READ_W-1:0] frozen;

   // ************************************************************
   // Functions
   // ************************************************************
   // Clamp a 12-bit signed raw code, LSB = 0.25 C, to the 11-bit maximum; negatives are not clamped
   function automatic logic [TMR_READ_W-1:0] tmr_clamp(input logic [11:0] raw);
      if (!raw[11] && (raw[10] || raw[9:0] == 10'h3ff)) begin
         tmr_clamp = TMR_CODE_MAX;
      end else if (raw[11]) begin
         tmr_clamp = {1'b1, raw[9:0]};
      end else begin
         tmr_clamp = raw[10:0];
      end
   endfunction : tmr_clamp

   // Next channel in the conversion rotation
   function automatic tmr_seq_t tmr_next(input tmr_seq_t cur);
      case (cur)
         TMR_SEQ_CH1: tmr_next = TMR_SEQ_CH2;
         TMR_SEQ_CH2: tmr_next = TMR_SEQ_INT;
         TMR_SEQ_INT: tmr_next = TMR_SEQ_CH1;
         default:     tmr_next = TMR_SEQ_CH1;
      endcase
   endfunction : tmr_next

   // ************************************************************
   // Channels
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < TMR_NUM_CH; g++) begin : g_ch
         // Sample accepted only for the channel currently converting
         assign upd[g] = i_ch_sample_valid[g] & s_q.convert[g];
         assign samp[g*TMR_READ_W +: TMR_READ_W] = tmr_clamp(i_ch_sample[g*12 +: 12]);
         assign frz[g] = i_reg_rd & (i_reg_addr == TMR_OFS_CH1_UPPER + 8'(2*g));
         tmr_channel u_ch (
            .i_sys_clk (i_sys_clk),
            .i_rst_n   (i_rst_n),
            .i_ce      (i_ce),
            .i_enable  (i_ch_enable[g]),
            .i_update  (upd[g]),
            .i_sample  (samp[g*TMR_READ_W +: TMR_READ_W]),
            .i_freeze  (frz[g]),
            .o_live    (live[g*TMR_READ_W +: TMR_READ_W]),
            .o_frozen  (frozen[g*TMR_READ_W +: TMR_READ_W])
         );
      end
   endgenerate

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [TMR_READ_W-1:0] v;
      v   = '0;
      s_d = s_q;

      // Round robin over enabled channels; each takes one slot
      s_d.convert = '0;
      if (i_ch_enable == '0) begin
         s_d.slot_cnt = '0;
      end else if (s_q.slot_cnt >= 16'(SLOT_CYC - 1)) begin
         s_d.slot_cnt = '0;
         s_d.seq      = tmr_next(s_q.seq);
         if (i_ch_enable[tmr_next(s_q.seq)]) begin
            s_d.convert[tmr_next(s_q.seq)] = 1'b1;
         end else if (i_ch_enable[tmr_next(tmr_next(s_q.seq))]) begin
            s_d.seq = tmr_next(tmr_next(s_q.seq));
            s_d.convert[tmr_next(tmr_next(s_q.seq))] = 1'b1;
         end else begin
            s_d.convert[s_q.seq] = i_ch_enable[s_q.seq];
            s_d.seq = s_q.seq;
         end
      end else begin
         s_d.slot_cnt = s_q.slot_cnt + 16'h0001;
         s_d.convert  = s_q.convert;
      end

      // Register write
      if (i_reg_wr && i_reg_addr == TMR_OFS_OUTPUT_OVERRIDE) begin
         s_d.ovr = i_reg_wdata[TMR_OVR_W-1:0];
      end

      // Register read data, captured on the read strobe
      if (i_reg_rd) begin
         case (i_reg_addr)
            TMR_OFS_OUTPUT_OVERRIDE: s_d.rdata = {2'b00, s_q.ovr};
            TMR_OFS_CH1_UPPER: s_d.rdata = live[0*TMR_READ_W+3 +: 8];
            TMR_OFS_CH2_UPPER: s_d.rdata = live[1*TMR_READ_W+3 +: 8];
            TMR_OFS_INT_UPPER: s_d.rdata = live[2*TMR_READ_W+3 +: 8];
            TMR_OFS_CH1_LOWER: begin
               v = frozen[0*TMR_READ_W +: TMR_READ_W];
               s_d.rdata = {v[2:0], 5'h00};
            end
            TMR_OFS_CH2_LOWER: begin
               v = frozen[1*TMR_READ_W +: TMR_READ_W];
               s_d.rdata = {v[2:0], 5'h00};
            end
            TMR_OFS_INT_LOWER: begin
               v = frozen[2*TMR_READ_W +: TMR_READ_W];
               s_d.rdata = {v[2:0], 5'h00};
            end
            TMR_OFS_ALARM_FIRST:  s_d.rdata = {5'h00, i_alarm_first};
            TMR_OFS_ALARM_SECOND: s_d.rdata = {5'h00, i_alarm_second};
            default: s_d.rdata = TMR_RD_UNMAPPED;
         endcase
      end

      // Outputs under host control follow the override bit
      s_d.outs = (i_out_host_ctl & s_q.ovr) | (~i_out_host_ctl & i_out_default);
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '{ovr: TMR_OVR_RESET, seq: TMR_SEQ_INT, slot_cnt: 16'h0000,
                  convert: 3'h0, rdata: 8'h00, outs: 6'h00};
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_reg_rdata            = s_q.rdata;
   assign o_ch_convert           = s_q.convert;
   assign o_general_output_two   = s_q.outs[TMR_OVR_GP2_BIT];
   assign o_general_output_three = s_q.outs[TMR_OVR_GP3_BIT];
   assign o_hv_output            = s_q.outs[TMR_OVR_HV1_BIT +: 4];
endmodule : tmr_readout

// [tmr_readout_props.sv]
`timescale 1ns/10ps
// ************
// Port checker
// ************
module tmr_readout_chk #(
   parameter int SLOT_CYC = 4
) (
   input wire logic       i_sys_clk,
   input wire logic       i_rst_n,
   input wire logic       i_ce,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [2:0] o_ch_convert,
   input wire logic [2:0] i_alarm_first,
   input wire logic [2:0] i_alarm_second,
   input wire logic [5:0] i_out_host_ctl,
   input wire logic [5:0] i_out_default,
   input wire logic [3:0] o_hv_output
);
   // Accepted requests
   wire rd_go = i_reg_rd & i_ce;
   wire wr_go = i_reg_wr & i_ce;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_ovr_pad_zero : assert property (rd_go && i_reg_addr == 8'h70 |=> o_reg_rdata[7:6] == 2'h0)
      else $error("override pad bits set");
   a_ovr_read_back : assert property (wr_go && i_reg_addr == 8'h70 ##1 !wr_go ##1 rd_go && i_reg_addr == 8'h70 |=> o_reg_rdata == {2'h0, $past(i_reg_wdata[5:0], 3)})
      else $error("override readback wrong");
   a_alarm_first_map : assert property (rd_go && i_reg_addr == 8'h86 |=> o_reg_rdata == {5'h00, $past(i_alarm_first)})
      else $error("first alarm byte wrong");
   a_alarm_second_map : assert property (rd_go && i_reg_addr == 8'h87 |=> o_reg_rdata == {5'h00, $past(i_alarm_second)})
      else $error("second alarm byte wrong");
   a_lower_pad_zero : assert property (rd_go && (i_reg_addr == 8'h81 || i_reg_addr == 8'h83 || i_reg_addr == 8'h85) |=> o_reg_rdata[4:0] == 5'h00)
      else $error("lower byte pad set");
   a_unmapped_read_zero : assert property (rd_go && i_reg_addr != 8'h70 && (i_reg_addr < 8'h80 || i_reg_addr > 8'h87) |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_slot_one_hot : assert property ($onehot0(o_ch_convert))
      else $error("two conversion slots at once");
   a_default_output : assert property ($past(i_ce) && $past(i_out_host_ctl[5:2]) == 4'h0 |-> o_hv_output == $past(i_out_default[5:2]))
      else $error("output ignores default");
endmodule : tmr_readout_chk
bind tmr_readout tmr_readout_chk #(.SLOT_CYC(SLOT_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_ch_convert(o_ch_convert), .i_alarm_first(i_alarm_first),
   .i_alarm_second(i_alarm_second), .i_out_host_ctl(i_out_host_ctl), .i_out_default(i_out_default),
   .o_hv_output(o_hv_output));

// [tmr_readout_test.sv]
`timescale 1ns/10ps
module tmr_readout_test;
   import tmr_pkg::*;
   localparam int SLOT = 4;
   logic        clk, rst_n, wr, rd, gp2, gp3;
   logic [7:0]  addr, wdata, rdata, d, v;
   logic [2:0]  en, sv, conv, a1, a2;
   logic [35:0] smp;
   logic [5:0]  hc, df;
   logic [3:0]  hv;
   logic [10:0] live [3];
   logic [10:0] frz [3];
   logic [11:0] raw;
   int          errors, num_checks, n, t, g;
   tmr_readout #(.SLOT_CYC(SLOT)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_ch_enable(en), .i_ch_sample_valid(sv), .i_ch_sample(smp), .o_ch_convert(conv),
      .i_alarm_first(a1), .i_alarm_second(a2), .i_out_host_ctl(hc), .i_out_default(df),
      .o_general_output_two(gp2), .o_general_output_three(gp3), .o_hv_output(hv));
   tmr_host_model host (.i_sys_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_addr(addr), .o_reg_wdata(wdata));
   // System clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // Waits for the start of a channel's slot, counting cycles
   task automatic wait_rise(input int c, output int w);
      logic p;
      p = 1'b1;
      for (w = 0; w < 200 && !(conv[c] && !p); w++) begin
         p = conv[c];
         @(posedge clk);
         #1;
      end
      if (w == 200) begin
         errors++;
         wrap_up;
      end
   endtask : wait_rise
   // Hands one raw sample to a channel inside its slot
   task automatic feed(input int c, input logic [11:0] r);
      int w;
      wait_rise(c, w);
      smp[12*c+:12] = r;
      sv[c] = 1'b1;
      @(posedge clk);
      #1;
      sv[c] = 1'b0;
      live[c] = (!r[11] && r >= 12'h3ff) ? 11'h3ff : {r[11], r[9:0]};
   endtask : feed
   // Reads upper then lower byte, optionally with a new sample between
   task automatic pair(input int c, input logic [11:0] mid, input bit f);
      host.xfer(1'b0, TMR_OFS_CH1_UPPER + 8'(2 * c), 8'h00, d);
      frz[c] = live[c];
      chk(d, live[c][10:3]);
      if (f) feed(c, mid);
      host.xfer(1'b0, TMR_OFS_CH1_LOWER + 8'(2 * c), 8'h00, d);
      chk(d, {frz[c][2:0], 5'h00});
   endtask : pair
   // Main sequence
   initial begin
      {rst_n, en, sv, smp, a1, a2, hc, df} = '0;
      errors = 0;
      num_checks = 0;
      raw = 12'($urandom(72128));
      for (g = 0; g < 3; g++) {live[g], frz[g]} = {TMR_CODE_DISABLED, TMR_CODE_DISABLED};
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      host.xfer(1'b0, TMR_OFS_OUTPUT_OVERRIDE, 8'h00, d);
      chk(d, 8'h00);
      for (g = 0; g < 3; g++) pair(g, 12'h000, 0);
      host.xfer(1'b1, TMR_OFS_CH1_UPPER, 8'h55, d);
      pair(0, 12'h000, 0);
      host.xfer(1'b0, 8'h90, 8'h00, d);
      chk(d, 8'h00);
      repeat (8) begin
         {v, hc, df} = 20'($urandom);
         host.xfer(1'b1, TMR_OFS_OUTPUT_OVERRIDE, v, d);
         host.xfer(1'b0, TMR_OFS_OUTPUT_OVERRIDE, 8'h00, d);
         chk(d, {2'h0, v[5:0]});
         chk({hv, gp3, gp2}, (hc & v[5:0]) | (~hc & df));
      end
      // Two of three channels share the converter, so channel one refreshes every two slots
      en = 3'h5;
      repeat (2) wait_rise(0, t);
      wait_rise(0, n);
      chk(n, 2 * SLOT);
      en = 3'h7;
      repeat (2) wait_rise(0, t);
      wait_rise(0, n);
      chk(n, 3 * SLOT);
      for (g = 0; g < 12; g++) begin
         raw = g == 0 ? 12'h400 : g == 1 ? 12'hf00 : g == 2 ? 12'h001 : 12'($urandom);
         feed(g % 3, raw);
         pair(g % 3, 12'h000, 0);
      end
      feed(1, 12'h123);
      pair(1, 12'h0ff, 1);
      pair(1, 12'h000, 0);
      repeat (6) begin
         {a1, a2} = 6'($urandom);
         host.xfer(1'b0, TMR_OFS_ALARM_FIRST, 8'h00, d);
         chk(d, {5'h00, a1});
         host.xfer(1'b0, TMR_OFS_ALARM_SECOND, 8'h00, d);
         chk(d, {5'h00, a2});
      end
      en = 3'h5;
      repeat (2) @(posedge clk);
      #1;
      live[1] = TMR_CODE_DISABLED;
      pair(1, 12'h000, 0);
      wrap_up;
   end
endmodule : tmr_readout_test
